// *** common/tpm_pkg.sv ***
// Constants and types for the timer mode block
// Operation
// RULE_01: PWM1: reference active while count below compare
// RULE_02: PWM2: reference inactive while count below compare
// RULE_03: PWM input only on channels one, two
// RULE_04: PWM input: paths take opposite polarities
// RULE_05: Software selects reset mode for PWM input
// RULE_06: One-shot stops counter at update, output frozen; only an update in a cycle with a counter tick stops it
// RULE_07: Update clears counter run bit in one-shot; only an update in a cycle with a counter tick clears it
// RULE_08: One-shot delay and width from compare, reload
// RULE_09: Mode codes 100/101 force reference inactive/active
// RULE_10: Forced outputs still raise compare flag, DMA
// RULE_11: Encoder counts on A, B or both
// RULE_12: Encoder counts on valid filtered input transitions
// RULE_13: Encoder direction from edge and other level
// RULE_14: Encoder direction read-only, recomputed each transition
// RULE_15: Slave codes 100 reset, 101 gated, 110 trigger
// RULE_16: Reset mode: trigger rise reinitializes, updates
// RULE_17: Gated mode: count only while trigger high
// RULE_18: Trigger mode: rise starts counter, never stops
// RULE_19: Interrupts on update, trigger, compare events
// RULE_20: DMA requests enabled independently per event
// RULE_21: Clear enable: external trigger forces reference low; only ch1 is cleared, the ch2 clear enable has no effect
// RULE_22: Clear disabled: external trigger has no effect
package tpm_pkg;
	localparam int CW = 16;
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_SLAVE = 4'h1;
	localparam logic [3:0] ADDR_IEN = 4'h2;
	localparam logic [3:0] ADDR_STS = 4'h3;
	localparam logic [3:0] ADDR_CHMODE = 4'h4;
	localparam logic [3:0] ADDR_CNT = 4'h5;
	localparam logic [3:0] ADDR_PSC = 4'h6;
	localparam logic [3:0] ADDR_RELOAD = 4'h7;
	localparam logic [3:0] ADDR_CMP1 = 4'h8;
	localparam logic [3:0] ADDR_CMP2 = 4'h9;
	localparam logic [3:0] ADDR_EVGEN = 4'hA;
	localparam int CTRL_RUN = 0;
	localparam int CTRL_ONESHOT = 1;
	localparam int CTRL_DIR = 2;
	localparam int STS_UPD = 0;
	localparam int STS_CC1 = 1;
	localparam int STS_CC2 = 2;
	localparam int STS_TRG = 3;
	localparam int IEN_DMA_SHIFT = 4;
	localparam logic [2:0] SMS_OFF = 3'h0;
	localparam logic [2:0] SMS_ENC_A = 3'h1;
	localparam logic [2:0] SMS_ENC_B = 3'h2;
	localparam logic [2:0] SMS_ENC_AB = 3'h3;
	localparam logic [2:0] SMS_RESET = 3'h4;
	localparam logic [2:0] SMS_GATED = 3'h5;
	localparam logic [2:0] SMS_TRIGGER = 3'h6;
	localparam logic [2:0] OCM_FORCE_LOW = 3'h4;
	localparam logic [2:0] OCM_FORCE_HIGH = 3'h5;
	localparam logic [2:0] OCM_PWM1 = 3'h6;
	localparam logic [2:0] OCM_PWM2 = 3'h7;
	localparam logic [1:0] DIRSEL_OUT = 2'h0;
	localparam logic [1:0] DIRSEL_TI1 = 2'h1;
	localparam logic [1:0] DIRSEL_TI2 = 2'h2;
	localparam int FILT_W = 4;

	typedef struct packed {
		logic [2:0] output_compare_mode;
		logic [1:0] channel_direction_select;
		logic reference_clear_enable;
		logic [FILT_W-1:0] input_filter;
		logic input_polarity;
	} tpm_chan_s;

	typedef struct packed {
		logic [CW-1:0] count_value;
		logic [CW-1:0] psc_cnt;
		logic [CW-1:0] psc_val;
		logic [CW-1:0] reload_value;
		logic [CW-1:0] cmp1;
		logic [CW-1:0] cmp2;
		logic counter_run;
		logic one_shot_enable;
		logic count_direction;
		logic [2:0] slave_mode_select;
		logic [7:0] ien;
		logic [3:0] sts;
		tpm_chan_s ch1;
		tpm_chan_s ch2;
		logic [1:0] fa_hist;
		logic [1:0] fb_hist;
		logic [FILT_W-1:0] fa_cnt;
		logic [FILT_W-1:0] fb_cnt;
		logic fa;
		logic fb;
		logic trg_d;
		logic ref_clr;
		logic ref1;
		logic ref2;
		logic [CW-1:0] rdata;
		logic [3:0] dma;
	} tpm_state_s;
endpackage : tpm_pkg

// *** design/tpm_timer.sv ***
// Timer core: PWM, one-shot, forced output, encoder and slave modes
`timescale 1ns/100ps
module tpm_timer
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [tpm_pkg::CW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [tpm_pkg::CW-1:0] rdata_o,
	input wire logic encoder_input_a_i,
	input wire logic encoder_input_b_i,
	input wire logic selected_trigger_input_i,
	input wire logic filtered_external_trigger_i,
	output logic ref1_o,
	output logic ref2_o,
	output logic [3:0] dma_req_o,
	output logic [3:0] irq_flags_o
);
	tpm_pkg::tpm_state_s s_reg;
	tpm_pkg::tpm_state_s s_next;

	always_comb
	begin
		logic ta;
		logic tb;
		logic rise_a;
		logic fall_a;
		logic rise_b;
		logic fall_b;
		logic enc_en;
		logic enc_step;
		logic enc_down;
		logic trg_rise;
		logic tick;
		logic upd;
		logic m1;
		logic m2;
		logic [3:0] ev;
		logic [3:0] clr;
		s_next = s_reg;
		clr = 4'h0;
		upd = 1'b0;
		tick = 1'b0;
		// Polarity applied, then a sample filter per input
		ta = encoder_input_a_i ^ s_reg.ch1.input_polarity; // [RULE_12]
		tb = encoder_input_b_i ^ s_reg.ch2.input_polarity; // [RULE_12]
		if (s_reg.ch1.channel_direction_select == tpm_pkg::DIRSEL_TI1 &&
			s_reg.ch2.channel_direction_select == tpm_pkg::DIRSEL_TI1)
		begin
			tb = encoder_input_a_i ^ ~s_reg.ch1.input_polarity; // [RULE_03] [RULE_04]
		end
		s_next.fa_hist = {s_reg.fa_hist[0], ta};
		s_next.fb_hist = {s_reg.fb_hist[0], tb};
		if (s_reg.fa_hist[1] == s_reg.fa)
			s_next.fa_cnt = '0;
		else if (s_reg.fa_cnt >= s_reg.ch1.input_filter)
		begin
			s_next.fa = s_reg.fa_hist[1]; // [RULE_12]
			s_next.fa_cnt = '0;
		end
		else
			s_next.fa_cnt = s_reg.fa_cnt + 1'b1;
		if (s_reg.fb_hist[1] == s_reg.fb)
			s_next.fb_cnt = '0;
		else if (s_reg.fb_cnt >= s_reg.ch2.input_filter)
		begin
			s_next.fb = s_reg.fb_hist[1]; // [RULE_12]
			s_next.fb_cnt = '0;
		end
		else
			s_next.fb_cnt = s_reg.fb_cnt + 1'b1;
		rise_a = s_next.fa & ~s_reg.fa;
		fall_a = ~s_next.fa & s_reg.fa;
		rise_b = s_next.fb & ~s_reg.fb;
		fall_b = ~s_next.fb & s_reg.fb;
		// Encoder stepping and direction
		enc_step = 1'b0;
		enc_down = s_reg.count_direction;
		enc_en = 1'b0;
		case (s_reg.slave_mode_select)
			tpm_pkg::SMS_ENC_A, tpm_pkg::SMS_ENC_B, tpm_pkg::SMS_ENC_AB:
				enc_en = 1'b1;
			default:
				enc_en = 1'b0;
		endcase
		if (s_reg.slave_mode_select != tpm_pkg::SMS_ENC_B && (rise_a | fall_a))
		begin
			enc_step = 1'b1; // [RULE_11]
			enc_down = rise_a ? s_reg.fb : ~s_reg.fb; // [RULE_13]
		end
		else if (s_reg.slave_mode_select != tpm_pkg::SMS_ENC_A && (rise_b | fall_b))
		begin
			enc_step = 1'b1; // [RULE_11]
			enc_down = rise_b ? ~s_reg.fa : s_reg.fa; // [RULE_13]
		end
		// Slave trigger handling
		s_next.trg_d = selected_trigger_input_i;
		trg_rise = selected_trigger_input_i & ~s_reg.trg_d;
		ev = 4'h0;
		if (trg_rise && s_reg.slave_mode_select == tpm_pkg::SMS_TRIGGER)
		begin
			s_next.counter_run = 1'b1; // [RULE_18]
			ev[tpm_pkg::STS_TRG] = 1'b1;
		end
		if (trg_rise && s_reg.slave_mode_select == tpm_pkg::SMS_RESET)
			ev[tpm_pkg::STS_TRG] = 1'b1; // [RULE_19]
		// Time base
		if (enc_en)
		begin
			if (s_reg.counter_run && enc_step)
			begin
				s_next.count_direction = enc_down; // [RULE_14]
				if (enc_down)
					s_next.count_value = (s_reg.count_value == '0) ? s_reg.reload_value :
						s_reg.count_value - 1'b1;
				else
					s_next.count_value = (s_reg.count_value >= s_reg.reload_value) ? '0 :
						s_reg.count_value + 1'b1;
			end
		end
		else if (s_reg.counter_run && (s_reg.slave_mode_select != tpm_pkg::SMS_GATED ||
			selected_trigger_input_i)) // [RULE_17]
		begin
			if (s_reg.psc_cnt >= s_reg.psc_val)
			begin
				s_next.psc_cnt = '0;
				tick = 1'b1;
			end
			else
				s_next.psc_cnt = s_reg.psc_cnt + 1'b1;
		end
		if (tick)
		begin
			if (s_reg.count_direction)
			begin
				if (s_reg.count_value == '0)
				begin
					s_next.count_value = s_reg.reload_value;
					upd = 1'b1;
				end
				else
					s_next.count_value = s_reg.count_value - 1'b1;
			end
			else if (s_reg.count_value >= s_reg.reload_value)
			begin
				s_next.count_value = '0;
				upd = 1'b1;
			end
			else
				s_next.count_value = s_reg.count_value + 1'b1;
		end
		if (trg_rise && s_reg.slave_mode_select == tpm_pkg::SMS_RESET)
		begin
			s_next.count_value = s_reg.count_direction ? s_reg.reload_value : '0; // [RULE_16]
			s_next.psc_cnt = '0; // [RULE_16]
			upd = 1'b1; // [RULE_16]
		end
		// Software event generation
		if (wr_i && addr_i == tpm_pkg::ADDR_EVGEN && wdata_i[tpm_pkg::STS_UPD])
		begin
			s_next.count_value = s_reg.count_direction ? s_reg.reload_value : '0;
			s_next.psc_cnt = '0;
			upd = 1'b1;
		end
		if (upd && tick && s_reg.one_shot_enable)
			s_next.counter_run = 1'b0; // [RULE_06] [RULE_07]
		// Compare and output reference
		// Compare against the count being loaded so the stopping update leaves the PWM2 pulse ended
		m1 = s_next.count_value < s_reg.cmp1; // [RULE_08]
		m2 = s_next.count_value < s_reg.cmp2;
		if (s_reg.ch1.reference_clear_enable && filtered_external_trigger_i)
			s_next.ref_clr = 1'b1; // [RULE_21]
		else if (upd || !s_reg.ch1.reference_clear_enable)
			s_next.ref_clr = 1'b0; // [RULE_22]
		if (s_reg.counter_run)
		begin
			case (s_reg.ch1.output_compare_mode)
				tpm_pkg::OCM_FORCE_LOW: s_next.ref1 = 1'b0; // [RULE_09]
				tpm_pkg::OCM_FORCE_HIGH: s_next.ref1 = 1'b1; // [RULE_09]
				tpm_pkg::OCM_PWM1: s_next.ref1 = m1; // [RULE_01] [RULE_08]
				tpm_pkg::OCM_PWM2: s_next.ref1 = ~m1; // [RULE_02] [RULE_08]
				default: s_next.ref1 = s_reg.ref1;
			endcase
			case (s_reg.ch2.output_compare_mode)
				tpm_pkg::OCM_FORCE_LOW: s_next.ref2 = 1'b0; // [RULE_09]
				tpm_pkg::OCM_FORCE_HIGH: s_next.ref2 = 1'b1; // [RULE_09]
				tpm_pkg::OCM_PWM1: s_next.ref2 = m2; // [RULE_01]
				tpm_pkg::OCM_PWM2: s_next.ref2 = ~m2; // [RULE_02]
				default: s_next.ref2 = s_reg.ref2;
			endcase
		end
		if (s_reg.ch1.channel_direction_select != tpm_pkg::DIRSEL_OUT)
			s_next.ref1 = 1'b0;
		if (s_reg.ch2.channel_direction_select != tpm_pkg::DIRSEL_OUT)
			s_next.ref2 = 1'b0;
		// Compare match events fire regardless of forcing
		ev[tpm_pkg::STS_UPD] = upd; // [RULE_19]
		if (s_reg.ch1.channel_direction_select == tpm_pkg::DIRSEL_OUT)
			ev[tpm_pkg::STS_CC1] = tick && s_reg.count_value == s_reg.cmp1; // [RULE_10]
		else
			ev[tpm_pkg::STS_CC1] = rise_a; // [RULE_03]
		if (s_reg.ch2.channel_direction_select == tpm_pkg::DIRSEL_OUT)
			ev[tpm_pkg::STS_CC2] = tick && s_reg.count_value == s_reg.cmp2; // [RULE_10]
		else
			ev[tpm_pkg::STS_CC2] = s_reg.ch2.channel_direction_select == tpm_pkg::DIRSEL_TI1 ?
				fall_a : rise_b; // [RULE_04]
		if (s_reg.ch1.channel_direction_select != tpm_pkg::DIRSEL_OUT && ev[tpm_pkg::STS_CC1])
			s_next.cmp1 = s_reg.count_value; // [RULE_03]
		if (s_reg.ch2.channel_direction_select != tpm_pkg::DIRSEL_OUT && ev[tpm_pkg::STS_CC2])
			s_next.cmp2 = s_reg.count_value; // [RULE_03]
		s_next.dma = ev & s_reg.ien[7:4]; // [RULE_20]
		// Register writes
		if (wr_i)
		begin
			case (addr_i)
				tpm_pkg::ADDR_CTRL:
				begin
					s_next.counter_run = wdata_i[tpm_pkg::CTRL_RUN];
					s_next.one_shot_enable = wdata_i[tpm_pkg::CTRL_ONESHOT];
					if (!enc_en)
						s_next.count_direction = wdata_i[tpm_pkg::CTRL_DIR]; // [RULE_14]
				end
				tpm_pkg::ADDR_SLAVE: s_next.slave_mode_select = wdata_i[2:0]; // [RULE_15]
				tpm_pkg::ADDR_IEN: s_next.ien = wdata_i[7:0];
				tpm_pkg::ADDR_STS: clr = ~wdata_i[3:0];
				tpm_pkg::ADDR_CHMODE:
				begin
					s_next.ch1.output_compare_mode = wdata_i[2:0];
					s_next.ch1.channel_direction_select = wdata_i[4:3];
					s_next.ch1.reference_clear_enable = wdata_i[5];
					s_next.ch1.input_polarity = wdata_i[6];
					s_next.ch1.input_filter = {3'h0, wdata_i[7]};
					s_next.ch2.output_compare_mode = wdata_i[10:8];
					s_next.ch2.channel_direction_select = wdata_i[12:11];
					s_next.ch2.reference_clear_enable = wdata_i[13];
					s_next.ch2.input_polarity = wdata_i[14];
					s_next.ch2.input_filter = {3'h0, wdata_i[15]};
				end
				tpm_pkg::ADDR_CNT: s_next.count_value = wdata_i;
				tpm_pkg::ADDR_PSC: s_next.psc_val = wdata_i;
				tpm_pkg::ADDR_RELOAD: s_next.reload_value = wdata_i;
				tpm_pkg::ADDR_CMP1: s_next.cmp1 = wdata_i;
				tpm_pkg::ADDR_CMP2: s_next.cmp2 = wdata_i;
				default: s_next.ien = s_reg.ien;
			endcase
		end
		// Sticky flags: set beats clear
		s_next.sts = (s_reg.sts & ~clr) | ev; // [RULE_19]
		// Read path
		s_next.rdata = '0;
		if (rd_i)
		begin
			case (addr_i)
				tpm_pkg::ADDR_CTRL: s_next.rdata = {13'h0000, s_reg.count_direction,
					s_reg.one_shot_enable, s_reg.counter_run};
				tpm_pkg::ADDR_SLAVE: s_next.rdata = {13'h0000, s_reg.slave_mode_select};
				tpm_pkg::ADDR_IEN: s_next.rdata = {8'h00, s_reg.ien};
				tpm_pkg::ADDR_STS: s_next.rdata = {12'h000, s_reg.sts};
				tpm_pkg::ADDR_CHMODE: s_next.rdata = {s_reg.ch2.input_filter[0],
					s_reg.ch2.input_polarity, s_reg.ch2.reference_clear_enable,
					s_reg.ch2.channel_direction_select, s_reg.ch2.output_compare_mode,
					s_reg.ch1.input_filter[0], s_reg.ch1.input_polarity,
					s_reg.ch1.reference_clear_enable, s_reg.ch1.channel_direction_select,
					s_reg.ch1.output_compare_mode};
				tpm_pkg::ADDR_CNT: s_next.rdata = s_reg.count_value;
				tpm_pkg::ADDR_PSC: s_next.rdata = s_reg.psc_val;
				tpm_pkg::ADDR_RELOAD: s_next.rdata = s_reg.reload_value;
				tpm_pkg::ADDR_CMP1: s_next.rdata = s_reg.cmp1;
				tpm_pkg::ADDR_CMP2: s_next.rdata = s_reg.cmp2;
				default: s_next.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign rdata_o = s_reg.rdata;
	assign ref1_o = s_reg.ref1 & ~s_reg.ref_clr; // [RULE_21] [RULE_22]
	assign ref2_o = s_reg.ref2;
	assign dma_req_o = s_reg.dma;
	assign irq_flags_o = s_reg.sts & s_reg.ien[3:0];
endmodule : tpm_timer

// *** test/tpm_enc_model.sv ***
// Quadrature encoder source model
`timescale 1ns/100ps
module tpm_enc_model
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic step_i,
	input wire logic dir_i,
	output logic a_o,
	output logic b_o
);
	logic [1:0] ph_reg;
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			ph_reg <= 2'h0;
		else if (step_i)
			ph_reg <= dir_i ? ph_reg - 2'h1 : ph_reg + 2'h1;
	end
	// One edge per step in Gray order
	assign a_o = ph_reg[0] ^ ph_reg[1];
	assign b_o = ph_reg[1];
endmodule : tpm_enc_model

// *** test/tpm_timer_sva.sv ***
// Port assertions for the timer mode block
`timescale 1ns/100ps
module tpm_timer_sva
(
	input wire logic clock_i,
	input wire logic nrst_i,
	input wire logic [3:0] addr_i,
	input wire logic [tpm_pkg::CW-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic selected_trigger_input_i,
	input wire logic filtered_external_trigger_i,
	input wire logic ref1_o,
	input wire logic ref2_o,
	input wire logic [3:0] dma_req_o,
	input wire logic [3:0] irq_flags_o
);
	logic [15:0] ctl, sm, ien, chm;
	logic ok;
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ctl <= 16'h0000;
			sm <= 16'h0000;
			ien <= 16'h0000;
			chm <= 16'h0000;
		end
		else if (wr_i)
		begin
			if (addr_i == tpm_pkg::ADDR_CTRL) ctl <= wdata_i;
			if (addr_i == tpm_pkg::ADDR_SLAVE) sm <= wdata_i;
			if (addr_i == tpm_pkg::ADDR_IEN) ien <= wdata_i;
			if (addr_i == tpm_pkg::ADDR_CHMODE) chm <= wdata_i;
		end
	end
	// Free-running, not one-shot, no slave mode
	assign ok = ctl[1:0] == 2'h1 && sm[2:0] == tpm_pkg::SMS_OFF;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	AST_IRQ_MASK: assert property ((irq_flags_o & ~ien[3:0] & ~$past(ien[3:0])) == 4'h0)
		else $error("irq flag without enable");
	AST_DMA_MASK: assert property ((dma_req_o & ~ien[7:4] & ~$past(ien[7:4])) == 4'h0)
		else $error("dma request without enable");
	AST_F1H: assert property ((ok && chm[5:0] == 6'h05) [*3] |-> ref1_o)
		else $error("ch1 force high lost");
	AST_F1L: assert property ((ok && chm[4:0] == 5'h04) [*3] |-> !ref1_o)
		else $error("ch1 force low lost");
	AST_F2H: assert property ((ok && chm[12:8] == 5'h05) [*3] |-> ref2_o)
		else $error("ch2 force high lost");
	AST_F2L: assert property ((ok && chm[12:8] == 5'h04) [*3] |-> !ref2_o)
		else $error("ch2 force low lost");
	AST_CLR: assert property ((ok && chm[5] && filtered_external_trigger_i) [*4] |-> !ref1_o)
		else $error("reference not cleared");
	AST_TRG: assert property (sm[2:0] == tpm_pkg::SMS_TRIGGER && ien[3]
		&& $rose(selected_trigger_input_i) |-> ##[1:4] irq_flags_o[3])
		else $error("no trigger event");
	AST_RST: assert property (sm[2:0] == tpm_pkg::SMS_RESET && ien[0]
		&& $rose(selected_trigger_input_i) |-> ##[1:4] irq_flags_o[0])
		else $error("no update on reset trigger");
	cover property (ok && ref1_o);
	cover property (dma_req_o[0]);
	cover property (irq_flags_o[3]);
endmodule : tpm_timer_sva
bind tpm_timer tpm_timer_sva chk_u (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i,
	.selected_trigger_input_i, .filtered_external_trigger_i, .ref1_o, .ref2_o,
	.dma_req_o, .irq_flags_o);

// *** test/tpm_timer_tb.sv ***
// Self-checking bench for the timer mode block
`timescale 1ns/100ps
module tpm_timer_tb;
	logic clock_i = 1'h0, nrst_i = 1'h0, wr_i = 1'h0, rd_i = 1'h0;
	logic st = 1'h0, dn = 1'h0, trg = 1'h0, etr = 1'h0, a, b, r1, r2;
	logic [3:0] addr_i = 4'h0, dma, irq;
	logic [15:0] wdata_i = 16'h0000, rdata_o, v, w, h, d, c, n, g;
	int failures = 0, n_checks = 0;
	always #2 clock_i = ~clock_i;
	tpm_enc_model src_u (.clock_i, .nrst_i, .step_i(st), .dir_i(dn), .a_o(a), .b_o(b));
	tpm_timer dut_u (.clock_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.encoder_input_a_i(a), .encoder_input_b_i(b), .selected_trigger_input_i(trg),
		.filtered_external_trigger_i(etr), .ref1_o(r1), .ref2_o(r2), .dma_req_o(dma),
		.irq_flags_o(irq));
	task automatic tk(input int k);
		repeat (k) @(posedge clock_i);
	endtask : tk
	task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
		@(posedge clock_i);
		wr_i <= 1'h1;
		addr_i <= ad;
		wdata_i <= dt;
		@(posedge clock_i);
		wr_i <= 1'h0;
	endtask : wr
	task automatic rd(input logic [3:0] ad, output logic [15:0] q);
		@(posedge clock_i);
		rd_i <= 1'h1;
		addr_i <= ad;
		@(posedge clock_i);
		rd_i <= 1'h0;
		#1;
		q = rdata_o;
	endtask : rd
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic final_report();
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	// Ten periods of reload 7 after settling
	task automatic pwm(input logic [15:0] md);
		wr(tpm_pkg::ADDR_CTRL, 16'h0000);
		wr(tpm_pkg::ADDR_CNT, 16'h0000);
		wr(tpm_pkg::ADDR_RELOAD, 16'h0007);
		wr(tpm_pkg::ADDR_CMP1, c);
		wr(tpm_pkg::ADDR_CHMODE, md);
		wr(tpm_pkg::ADDR_CTRL, 16'h0001);
		tk(16);
		h = 16'h0000;
		d = 16'h0000;
		g = 16'h0000;
		repeat (80)
		begin
			@(posedge clock_i);
			#1;
			h += {15'h0000, r1 === 1'h1};
			d += {15'h0000, dma[0] === 1'h1};
			g += {15'h0000, r2 === 1'h1};
		end
	endtask : pwm
	task automatic steps(input logic [15:0] k, input logic dir);
		repeat (k)
		begin
			@(posedge clock_i);
			st <= 1'h1;
			dn <= dir;
			@(posedge clock_i);
			st <= 1'h0;
			tk(6);
		end
	endtask : steps
	initial
	begin
		#400000;
		failures++;
		final_report();
	end
	initial
	begin
		v = 16'($urandom(10));
		tk(20);
		nrst_i <= 1'h1;
		rd(4'hF, v);
		chk("unmapped", v, 16'h0000);
		wr(tpm_pkg::ADDR_IEN, 16'h00FF);
		c = 16'($urandom_range(1, 7));
		pwm(16'h0006);
		chk("pwm1", h, c * 16'h000A);
		chk("dma", d, 16'h000A);
		chk("irq", {15'h0000, irq[0]}, 16'h0001);
		pwm(16'h0007);
		chk("pwm2", h, (16'h0008 - c) * 16'h000A);
		etr <= 1'h1;
		pwm(16'h0006);
		chk("noclr", h, c * 16'h000A);
		pwm(16'h0026);
		chk("clr", h, 16'h0000);
		etr <= 1'h0;
		wr(tpm_pkg::ADDR_IEN, 16'h000F);
		wr(tpm_pkg::ADDR_STS, 16'h0000);
		pwm(16'h0505);
		chk("fhi", h, 16'h0050);
		chk("fhi2", g, 16'h0050);
		chk("nodma", d, 16'h0000);
		rd(tpm_pkg::ADDR_STS, v);
		chk("ccflag", {15'h0000, v[tpm_pkg::STS_CC1]}, 16'h0001);
		pwm(16'h0404);
		chk("flo", h, 16'h0000);
		chk("flo2", g, 16'h0000);
		wr(tpm_pkg::ADDR_CTRL, 16'h0000);
		wr(tpm_pkg::ADDR_CNT, 16'h0000);
		wr(tpm_pkg::ADDR_CHMODE, 16'h0007);
		wr(tpm_pkg::ADDR_CTRL, 16'h0003);
		h = 16'h0000;
		repeat (30)
		begin
			@(posedge clock_i);
			#1;
			h += {15'h0000, r1 === 1'h1};
		end
		chk("ospulse", h, 16'h0008 - c);
		w = 16'h0001;
		for (int i = 0; i < 50 && w[0] !== 1'h0; i++)
			rd(tpm_pkg::ADDR_CTRL, w);
		chk("osrun", {15'h0000, w[0]}, 16'h0000);
		rd(tpm_pkg::ADDR_CNT, v);
		tk(20);
		rd(tpm_pkg::ADDR_CNT, w);
		chk("osstop", w, v);
		wr(tpm_pkg::ADDR_RELOAD, 16'hFFFF);
		for (int m = 1; m < 4; m++)
		begin
			wr(tpm_pkg::ADDR_SLAVE, 16'(m));
			wr(tpm_pkg::ADDR_CTRL, 16'h0001);
			n = 16'(4 * $urandom_range(1, 3));
			rd(tpm_pkg::ADDR_CNT, v);
			steps(n, 1'h0);
			rd(tpm_pkg::ADDR_CNT, w);
			chk("encup", w - v, (m == 3) ? n : n / 2);
			steps(n, 1'h1);
			rd(tpm_pkg::ADDR_CNT, v);
			chk("encdn", w - v, (m == 3) ? n : n / 2);
			wr(tpm_pkg::ADDR_CTRL, 16'h0001);
			rd(tpm_pkg::ADDR_CTRL, v);
			chk("dir", {15'h0000, v[2]}, 16'h0001);
		end
		wr(tpm_pkg::ADDR_SLAVE, 16'h0000);
		wr(tpm_pkg::ADDR_CTRL, 16'h0001);
		wr(tpm_pkg::ADDR_RELOAD, 16'hFFFF);
		wr(tpm_pkg::ADDR_SLAVE, 16'h0005);
		rd(tpm_pkg::ADDR_CNT, v);
		tk(20);
		rd(tpm_pkg::ADDR_CNT, w);
		chk("gate0", w, v);
		trg <= 1'h1;
		tk(20);
		rd(tpm_pkg::ADDR_CNT, v);
		chk("gate1", {15'h0000, v > w}, 16'h0001);
		trg <= 1'h0;
		wr(tpm_pkg::ADDR_CTRL, 16'h0000);
		wr(tpm_pkg::ADDR_SLAVE, 16'h0006);
		wr(tpm_pkg::ADDR_CNT, 16'h0050);
		trg <= 1'h1;
		tk(10);
		trg <= 1'h0;
		tk(10);
		rd(tpm_pkg::ADDR_CTRL, v);
		chk("trgrun", {15'h0000, v[0]}, 16'h0001);
		rd(tpm_pkg::ADDR_CNT, v);
		chk("trgcnt", {15'h0000, v > 16'h0050}, 16'h0001);
		wr(tpm_pkg::ADDR_SLAVE, 16'h0004);
		tk(40);
		wr(tpm_pkg::ADDR_STS, 16'h0000);
		trg <= 1'h1;
		tk(3);
		rd(tpm_pkg::ADDR_CNT, v);
		chk("rstcnt", {15'h0000, v < 16'h0010}, 16'h0001);
		chk("rstupd", {15'h0000, irq[0]}, 16'h0001);
		wr(tpm_pkg::ADDR_SLAVE, 16'h0000);
		wr(tpm_pkg::ADDR_CHMODE, 16'h0808);
		steps(16'h0003, 1'h0);
		rd(tpm_pkg::ADDR_CMP1, v);
		rd(tpm_pkg::ADDR_CMP2, w);
		chk("pwmin", w - v, 16'h0010);
		final_report();
	end
endmodule : tpm_timer_tb
